// >>> core/irq_ctrl_defs.svh
// register offsets, field positions and reset values of the interrupt source controller
`ifndef IRQ_CTRL_DEFS_SVH
`define IRQ_CTRL_DEFS_SVH

// byte offsets, one register per byte address, data in bits 7:0
`define IRQ_OFS_LEVEL_MASK_LOW 12'h0640
`define IRQ_OFS_LEVEL_MASK_HIGH 12'h0641
`define IRQ_OFS_EDGE_MASK 12'h0642
`define IRQ_OFS_DELIVERY_CTRL 12'h0643
`define IRQ_OFS_PRIORITY_BYTE0 12'h0644
`define IRQ_OFS_PRIORITY_BYTE1 12'h0645
`define IRQ_OFS_PRIORITY_BYTE2 12'h0646
`define IRQ_OFS_PENDING_BYTE0 12'h0648
`define IRQ_OFS_PENDING_BYTE1 12'h0649
`define IRQ_OFS_PENDING_BYTE2 12'h064a

// implemented bits of each byte
`define IRQ_LEVEL_LOW_VALID 8'hd7
`define IRQ_LEVEL_HIGH_VALID 8'hf0
`define IRQ_EDGE_VALID 8'hec
`define IRQ_DELIVERY_VALID 8'h03
`define IRQ_ENABLE_BIT 0

// reset values
`define IRQ_RESET_BYTE 8'h00
`define IRQ_RESET_WORD 32'h0000_0000
`define IRQ_RESET_LEVEL 16'h0000
`define IRQ_RESET_VEC 24'h00_0000

// bus response codes
`define IRQ_RESP_OKAY 2'h0
`define IRQ_RESP_DECODE_ERR 2'h3

// number of source bit positions
`define IRQ_LEVEL_COUNT 16
`define IRQ_EDGE_COUNT 8
`define IRQ_SOURCE_COUNT 24

`endif

// >>> core/irq_ctrl_pkg.sv
// types shared by the interrupt source controller files
package irq_ctrl_pkg;
  typedef logic [23:0] source_vec_t;
  typedef logic [7:0] reg_byte_t;
  typedef logic [11:0] byte_addr_t;
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ANSWER
  } bus_state_t;
endpackage

// >>> core/irq_pending_latch.sv
// edge-type pending flag latch with write-one-to-clear
`timescale 1ns/100ps
`include "irq_ctrl_defs.svh"

module irq_pending_latch (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // synchronised edge requests and clear strobe
  input wire logic [7:0] edge_req_i,
  input wire logic clear_stb_i,
  input wire logic [7:0] clear_bits_i,
  // latched flags
  output logic [7:0] flags_o
);

  logic [7:0] prev_q;
  logic [7:0] prev_d;
  logic [7:0] flags_q;
  logic [7:0] flags_d;

  // rising edge catch, set wins over clear
  always_comb begin
    logic [7:0] rise;
    rise = edge_req_i & ~prev_q;
    prev_d = edge_req_i;
    flags_d = flags_q;
    if (clear_stb_i) begin
      flags_d = flags_d & ~clear_bits_i;
    end
    flags_d = (flags_d | rise) & `IRQ_EDGE_VALID;
  end

  // register stage
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      prev_q <= `IRQ_RESET_BYTE;
      flags_q <= `IRQ_RESET_BYTE;
    end else begin
      prev_q <= prev_d;
      flags_q <= flags_d;
    end
  end

  assign flags_o = flags_q;

endmodule // irq_pending_latch

// >>> core/irq_source_ctrl.sv
// interrupt source controller: 15 sources in 24 bit positions, masks, priority, Avalon-MM registers
// Function
// - accept 10 level and 5 edge sources, in 16-bit and 8-bit fields
// - level mask byte low enables listed sources
// - level mask byte high, low nibble reserved
// - edge mask byte, bits 4,1,0 reserved
// - enable bit gates all requests
// - mode bit 1 stored, no function
// - priority bytes, one marks high priority
// - high-priority requests presented before low
// - raised source sets its pending flag
// - counter0 bit 0, pin bit 18
// - edge flag held until write one
// - level flags follow originating module status
// - host command and software level sources
// - wakeup edge source from 32kHz counter
`timescale 1ns/100ps
`include "irq_ctrl_defs.svh"

module irq_source_ctrl (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [11:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [1:0] avs_response_o,
  // level sources from other modules
  input wire logic [2:0] counter_request_i,
  input wire logic dma_request_i,
  input wire logic serial_port_request_i,
  input wire logic host_command_request_i,
  input wire logic software_request_i,
  input wire logic radio_request_i,
  input wire logic pwm_request_i,
  input wire logic analog_request_i,
  // edge sources from pins and power management
  input wire logic pin_request_i,
  input wire logic wakeup_request_i,
  input wire logic [2:0] routed_pin_request_i,
  // request to processor
  output logic irq_request_o,
  output logic irq_high_priority_o,
  output irq_ctrl_pkg::source_vec_t irq_selected_o
);

  import irq_ctrl_pkg::*;

  // ****************************************************************
  // helper functions
  // ****************************************************************

  // lowest set bit of a source vector, one-hot
  function automatic source_vec_t lowest_one(input source_vec_t v);
    source_vec_t r;
    r = v & (~v + 24'h00_0001);
    return r;
  endfunction

  // merge one byte lane into a register under its valid mask
  function automatic reg_byte_t merge_byte(input reg_byte_t old, input reg_byte_t wr, input reg_byte_t valid);
    reg_byte_t r;
    r = (old & ~valid) | (wr & valid);
    return r;
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************

  // raw pin words and the two stages that tame metastability
  logic [15:0] lvl_raw;
  logic [7:0] edge_raw;
  logic [15:0] lvl_meta_q;
  logic [15:0] lvl_sync_q;
  logic [7:0] edge_meta_q;
  logic [7:0] edge_sync_q;
  logic [15:0] lvl_meta_d;
  logic [7:0] edge_meta_d;

  // pack sources in mask bit order
  assign lvl_raw = {analog_request_i, pwm_request_i, radio_request_i, software_request_i, 4'h0,
                    host_command_request_i, serial_port_request_i, 1'b0, dma_request_i, 1'b0,
                    counter_request_i};
  assign edge_raw = {routed_pin_request_i, 1'b0, wakeup_request_i, pin_request_i, 2'b00};

  // first stage next values
  always_comb begin
    lvl_meta_d = lvl_raw;
    edge_meta_d = edge_raw;
  end

  // two-flop synchronisers
  // only the second stage feeds logic, the first may still be settling
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      lvl_meta_q <= `IRQ_RESET_LEVEL;
      lvl_sync_q <= `IRQ_RESET_LEVEL;
      edge_meta_q <= `IRQ_RESET_BYTE;
      edge_sync_q <= `IRQ_RESET_BYTE;
    end else begin
      lvl_meta_q <= lvl_meta_d;
      lvl_sync_q <= lvl_meta_q;
      edge_meta_q <= edge_meta_d;
      edge_sync_q <= edge_meta_q;
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************

  // configuration state and bus strobes
  reg_byte_t mask0_q, mask0_d;
  reg_byte_t mask1_q, mask1_d;
  reg_byte_t mask2_q, mask2_d;
  reg_byte_t mode_q, mode_d;
  reg_byte_t prio0_q, prio0_d;
  reg_byte_t prio1_q, prio1_d;
  reg_byte_t prio2_q, prio2_d;
  logic wr_take;
  logic wr_commit;
  logic rd_take;
  logic clear_stb;
  reg_byte_t clear_bits;
  reg_byte_t wbyte;
  logic addr_hit;
  bus_state_t bus_q, bus_d;

  // one byte of write data taken from byte lane 0, zero when that lane is not enabled
  assign wbyte = avs_byteenable_i[0] ? avs_writedata_i[7:0] : `IRQ_RESET_BYTE;
  assign wr_take = (bus_q == BUS_IDLE) && avs_write_i;
  assign rd_take = (bus_q == BUS_IDLE) && avs_read_i;
  // a write lands on the answer edge, where the master samples waitrequest low
  // and still holds address and data; the taking edge only starts the answer
  assign wr_commit = (bus_q == BUS_ANSWER) && avs_write_i;

  // register writes
  always_comb begin
    mask0_d = mask0_q;
    mask1_d = mask1_q;
    mask2_d = mask2_q;
    mode_d = mode_q;
    prio0_d = prio0_q;
    prio1_d = prio1_q;
    prio2_d = prio2_q;
    clear_stb = 1'b0;
    clear_bits = `IRQ_RESET_BYTE;
    if (wr_commit && avs_byteenable_i[0]) begin
      unique case (avs_address_i)
        `IRQ_OFS_LEVEL_MASK_LOW: mask0_d = merge_byte(mask0_q, wbyte, `IRQ_LEVEL_LOW_VALID);
        `IRQ_OFS_LEVEL_MASK_HIGH: mask1_d = merge_byte(mask1_q, wbyte, `IRQ_LEVEL_HIGH_VALID);
        `IRQ_OFS_EDGE_MASK: mask2_d = merge_byte(mask2_q, wbyte, `IRQ_EDGE_VALID);
        `IRQ_OFS_DELIVERY_CTRL: mode_d = merge_byte(mode_q, wbyte, `IRQ_DELIVERY_VALID);
        `IRQ_OFS_PRIORITY_BYTE0: prio0_d = merge_byte(prio0_q, wbyte, `IRQ_LEVEL_LOW_VALID);
        `IRQ_OFS_PRIORITY_BYTE1: prio1_d = merge_byte(prio1_q, wbyte, `IRQ_LEVEL_HIGH_VALID);
        `IRQ_OFS_PRIORITY_BYTE2: prio2_d = merge_byte(prio2_q, wbyte, `IRQ_EDGE_VALID);
        `IRQ_OFS_PENDING_BYTE2: begin
          clear_stb = 1'b1;
          clear_bits = wbyte;
        end
        default: begin
        end
      endcase
    end
  end

  // register stage, all zero after reset
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mask0_q <= `IRQ_RESET_BYTE;
      mask1_q <= `IRQ_RESET_BYTE;
      mask2_q <= `IRQ_RESET_BYTE;
      mode_q <= `IRQ_RESET_BYTE;
      prio0_q <= `IRQ_RESET_BYTE;
      prio1_q <= `IRQ_RESET_BYTE;
      prio2_q <= `IRQ_RESET_BYTE;
    end else begin
      mask0_q <= mask0_d;
      mask1_q <= mask1_d;
      mask2_q <= mask2_d;
      mode_q <= mode_d;
      prio0_q <= prio0_d;
      prio1_q <= prio1_d;
      prio2_q <= prio2_d;
    end
  end

  // ****************************************************************
  // pending flags
  // ****************************************************************

  // latched edge flags and the full pending word
  logic [7:0] edge_flags;
  source_vec_t pending;

  irq_pending_latch u_edge_latch (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .edge_req_i(edge_sync_q),
    .clear_stb_i(clear_stb),
    .clear_bits_i(clear_bits),
    .flags_o(edge_flags)
  );

  // level flags mirror the source module status
  // no latch here: the source module owns the clear of a level flag
  assign pending = {edge_flags, lvl_sync_q & {`IRQ_LEVEL_HIGH_VALID, `IRQ_LEVEL_LOW_VALID}};

  // ****************************************************************
  // request and priority selection
  // ****************************************************************

  // selection state, registered so every output leaves a flip-flop
  source_vec_t active;
  source_vec_t high_active;
  source_vec_t sel_d, sel_q;
  logic req_d, req_q;
  logic hi_d, hi_q;

  // unmasked pending sources and the high-priority part of them
  assign active = pending & {mask2_q, mask1_q, mask0_q};
  assign high_active = active & {prio2_q, prio1_q, prio0_q};

  // request gated by enable, high-priority group first
  // within a group the lowest bit index wins, so the choice is stable
  always_comb begin
    req_d = mode_q[`IRQ_ENABLE_BIT] && (active != 24'h00_0000);
    hi_d = req_d && (high_active != 24'h00_0000);
    sel_d = 24'h00_0000;
    if (req_d) begin
      sel_d = hi_d ? lowest_one(high_active) : lowest_one(active);
    end
  end

  // request register stage
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      req_q <= 1'b0;
      hi_q <= 1'b0;
      sel_q <= `IRQ_RESET_VEC;
    end else begin
      req_q <= req_d;
      hi_q <= hi_d;
      sel_q <= sel_d;
    end
  end

  // processor outputs straight from the selection registers
  assign irq_request_o = req_q;
  assign irq_high_priority_o = hi_q;
  assign irq_selected_o = sel_q;

  // ****************************************************************
  // Avalon-MM answer
  // ****************************************************************

  // answer registers, held until the next answer
  logic [31:0] rdata_d, rdata_q;
  logic [1:0] resp_d, resp_q;
  reg_byte_t rsel;

  // readback mux
  // an address outside the map reads zero and flags a decode error
  always_comb begin
    addr_hit = 1'b1;
    rsel = `IRQ_RESET_BYTE;
    unique case (avs_address_i)
      `IRQ_OFS_LEVEL_MASK_LOW: rsel = mask0_q;
      `IRQ_OFS_LEVEL_MASK_HIGH: rsel = mask1_q;
      `IRQ_OFS_EDGE_MASK: rsel = mask2_q;
      `IRQ_OFS_DELIVERY_CTRL: rsel = mode_q;
      `IRQ_OFS_PRIORITY_BYTE0: rsel = prio0_q;
      `IRQ_OFS_PRIORITY_BYTE1: rsel = prio1_q;
      `IRQ_OFS_PRIORITY_BYTE2: rsel = prio2_q;
      `IRQ_OFS_PENDING_BYTE0: rsel = pending[7:0];
      `IRQ_OFS_PENDING_BYTE1: rsel = pending[15:8];
      `IRQ_OFS_PENDING_BYTE2: rsel = pending[23:16];
      default: addr_hit = 1'b0;
    endcase
  end

  // one wait cycle, answer in the second
  always_comb begin
    bus_d = bus_q;
    rdata_d = rdata_q;
    resp_d = resp_q;
    unique case (bus_q)
      BUS_IDLE: begin
        if (rd_take || wr_take) begin
          bus_d = BUS_ANSWER;
          rdata_d = rd_take ? {24'h00_0000, rsel} : `IRQ_RESET_WORD;
          resp_d = addr_hit ? `IRQ_RESP_OKAY : `IRQ_RESP_DECODE_ERR;
        end
      end
      BUS_ANSWER: begin
        bus_d = BUS_IDLE;
      end
    endcase
  end

  // bus state and answer register stage
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      bus_q <= BUS_IDLE;
      rdata_q <= `IRQ_RESET_WORD;
      resp_q <= `IRQ_RESP_OKAY;
    end else begin
      bus_q <= bus_d;
      rdata_q <= rdata_d;
      resp_q <= resp_d;
    end
  end

  // waitrequest low only in the answer cycle
  logic wait_d, wait_q;

  // high again from the answer edge on, and while idle
  always_comb begin
    wait_d = (bus_d != BUS_ANSWER);
  end

  // waitrequest register, high through reset
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= wait_d;
    end
  end

  // bus outputs straight from their registers
  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o = rdata_q;
  assign avs_response_o = resp_q;

endmodule // irq_source_ctrl

// >>> tb/cpu_irq_model.sv
// processor side model taking interrupt requests
`timescale 1ns/100ps
module cpu_irq_model (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // request from the controller
  input wire logic irq_request_i,
  input wire irq_ctrl_pkg::source_vec_t irq_selected_i,
  // last source taken
  output irq_ctrl_pkg::source_vec_t taken_o
);
  import irq_ctrl_pkg::*;
  // take the presented source while a request stands
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      taken_o <= 24'h00_0000;
    end else if (irq_request_i) begin
      taken_o <= irq_selected_i;
    end
  end
endmodule // cpu_irq_model

// >>> tb/irq_source_ctrl_assertions.sv
// concurrent checks on the interrupt source controller ports
`timescale 1ns/100ps
module irq_source_ctrl_checker (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // register bus
  input wire logic [11:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [1:0] avs_response_o,
  // request to processor
  input wire logic irq_request_o,
  input wire logic irq_high_priority_o,
  input wire irq_ctrl_pkg::source_vec_t irq_selected_o
);
  import irq_ctrl_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // ****************************************
  // bus and request relations
  // ****************************************
  reset_clears_a: assert property (disable iff (1'b0) rst_i |=> !irq_request_o && avs_waitrequest_o)
    else $error("outputs not cleared by reset");
  request_onehot_a: assert property (irq_request_o |-> $onehot(irq_selected_o))
    else $error("selected source not one-hot");
  high_needs_request_a: assert property (irq_high_priority_o |-> irq_request_o)
    else $error("high priority without request");
  upper_bytes_zero_a: assert property (!avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h00_0000)
    else $error("read data upper bytes not zero");
  unmapped_zero_a: assert property (!avs_waitrequest_o && avs_response_o == 2'b11 |-> avs_readdata_o == 32'h0)
    else $error("unmapped read returned data");
  answer_once_a: assert property ($fell(avs_waitrequest_o) |=> avs_waitrequest_o)
    else $error("answer longer than one cycle");
  answer_cause_a: assert property ($fell(avs_waitrequest_o) |-> $past(avs_read_i || avs_write_i, 1))
    else $error("answer without request");
  disable_quiet_a: assert property (avs_write_i && !avs_waitrequest_o && avs_address_i == 12'h0643 &&
    avs_byteenable_i[0] && !avs_writedata_i[0] |-> ##2 !irq_request_o) else $error("request after disable");
endmodule // irq_source_ctrl_checker
bind irq_source_ctrl irq_source_ctrl_checker irq_source_ctrl_checker_i (.ref_clk_i, .rst_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
  .avs_response_o, .irq_request_o, .irq_high_priority_o, .irq_selected_o);

// >>> tb/irq_source_ctrl_tb.sv
// self-checking bench for the interrupt source controller
`timescale 1ns/100ps
module irq_source_ctrl_tb;
  import irq_ctrl_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [11:0] avs_address_i = 12'h0000;
  logic avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [3:0] avs_byteenable_i = 4'h1;
  logic [2:0] counter_request_i = 3'h0, routed_pin_request_i = 3'h0;
  logic dma_request_i = 1'b0, serial_port_request_i = 1'b0, host_command_request_i = 1'b0;
  logic software_request_i = 1'b0, radio_request_i = 1'b0, pwm_request_i = 1'b0, analog_request_i = 1'b0;
  logic pin_request_i = 1'b0, wakeup_request_i = 1'b0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o, irq_request_o, irq_high_priority_o;
  logic [1:0] avs_response_o;
  source_vec_t irq_selected_o, taken;
  int fails = 0, n_compared = 0, cycles = 0;
  reg_byte_t rd;
  // ****************************************
  // clock, design and processor model
  // ****************************************
  always #2.5 ref_clk_i = ~ref_clk_i;
  irq_source_ctrl irq_source_ctrl_i (.ref_clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .avs_response_o,
    .counter_request_i, .dma_request_i, .serial_port_request_i, .host_command_request_i, .software_request_i,
    .radio_request_i, .pwm_request_i, .analog_request_i, .pin_request_i, .wakeup_request_i,
    .routed_pin_request_i, .irq_request_o, .irq_high_priority_o, .irq_selected_o);
  cpu_irq_model cpu_irq_model_i (.ref_clk_i, .rst_i, .irq_request_i(irq_request_o),
    .irq_selected_i(irq_selected_o), .taken_o(taken));
  // ****************************************
  // shared tasks
  // ****************************************
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task wr(input byte_addr_t a, input reg_byte_t d);
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h00_0000, d};
    avs_write_i <= 1'b1;
    do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
  endtask
  task rdchk(input byte_addr_t a, input reg_byte_t exp);
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_read_i <= 1'b1;
    do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o[7:0];
    avs_read_i <= 1'b0;
    check("register byte", {24'h00_0000, rd}, {24'h00_0000, exp});
  endtask
  task irqchk(input logic req, input source_vec_t sel);
    check("request", {31'h0, irq_request_o}, {31'h0, req});
    if (req) check("selected", {8'h00, irq_selected_o}, {8'h00, sel});
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_reset;
    for (int a = 12'h0640; a <= 12'h0646; a++) rdchk(a[11:0], 8'h00);
    check("response", {30'h0, avs_response_o}, 32'h0);
    $display("reset test done");
  endtask
  task t_regs;
    reg_byte_t exp [4];
    exp = '{8'hd7, 8'hf0, 8'hec, 8'h03};
    for (int i = 0; i < 4; i++) begin
      wr(12'h0640 + i[11:0], 8'hff);
      rdchk(12'h0640 + i[11:0], exp[i]);
      wr(12'h0640 + i[11:0], 8'h00);
    end
    avs_byteenable_i <= 4'h0;
    wr(12'h0640, 8'hff);
    avs_byteenable_i <= 4'h1;
    rdchk(12'h0640, 8'h00);
    wr(12'h0648, 8'hff);
    rdchk(12'h0648, 8'h00);
    wr(12'h0647, 8'hff);
    rdchk(12'h0647, 8'h00);
    check("response", {30'h0, avs_response_o}, 32'h3);
    $display("register test done");
  endtask
  task t_level;
    {counter_request_i, dma_request_i, serial_port_request_i, host_command_request_i} <= 6'h3f;
    {software_request_i, radio_request_i, pwm_request_i, analog_request_i} <= 4'hf;
    tick(3);
    rdchk(12'h0648, 8'hd7);
    rdchk(12'h0649, 8'hf0);
    irqchk(1'b0, 24'h00_0000);
    wr(12'h0640, 8'h01);
    wr(12'h0643, 8'h01);
    tick(2);
    irqchk(1'b1, 24'h00_0001);
    wr(12'h0643, 8'h00);
    tick(2);
    irqchk(1'b0, 24'h00_0000);
    wr(12'h0643, 8'h01);
    {counter_request_i, dma_request_i, serial_port_request_i, host_command_request_i} <= 6'h00;
    {software_request_i, radio_request_i, pwm_request_i, analog_request_i} <= 4'h0;
    tick(4);
    rdchk(12'h0648, 8'h00);
    irqchk(1'b0, 24'h00_0000);
    $display("level test done");
  endtask
  task t_edge;
    {pin_request_i, wakeup_request_i, routed_pin_request_i} <= 5'h1f;
    tick(4);
    {pin_request_i, wakeup_request_i, routed_pin_request_i} <= 5'h00;
    rdchk(12'h064a, 8'hec);
    wr(12'h0642, 8'h04);
    tick(3);
    irqchk(1'b1, 24'h04_0000);
    wr(12'h064a, 8'h04);
    tick(3);
    rdchk(12'h064a, 8'he8);
    irqchk(1'b0, 24'h00_0000);
    wr(12'h064a, 8'he8);
    rdchk(12'h064a, 8'h00);
    $display("edge test done");
  endtask
  task t_prio;
    counter_request_i <= 3'h1;
    analog_request_i <= 1'b1;
    wr(12'h0641, 8'h80);
    tick(3);
    irqchk(1'b1, 24'h00_0001);
    check("high flag", {31'h0, irq_high_priority_o}, 32'h0);
    wr(12'h0645, 8'h80);
    tick(3);
    irqchk(1'b1, 24'h00_8000);
    check("high flag", {31'h0, irq_high_priority_o}, 32'h1);
    check("taken", {8'h00, taken}, 32'h0000_8000);
    wr(12'h0645, 8'h00); // back to the default priority
    counter_request_i <= 3'h0;
    analog_request_i <= 1'b0;
    $display("priority test done");
  endtask
  // ****************************************
  // sequence and timeout
  // ****************************************
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      report_and_stop;
    end
  end
  initial begin
    tick(20);
    rst_i <= 1'b0;
    t_reset;
    t_regs;
    t_level;
    t_edge;
    t_prio;
    report_and_stop;
  end
endmodule // irq_source_ctrl_tb
